/* rtl/tot_pkg.sv */
package tot_pkg;
  // Register command codes
  localparam logic [7:0]  TOT_CMD_LIMIT      = 8'h62;
  localparam logic [7:0]  TOT_CMD_ACTION     = 8'h63;
  // Reset values of the two registers
  localparam logic [15:0] TOT_LIMIT_RST      = 16'h0000;
  localparam logic [7:0]  TOT_ACTION_RST     = 8'h00;
  // Field positions inside the action byte
  localparam int          TOT_RESP_HI        = 7;
  localparam int          TOT_RESP_LO        = 6;
  localparam int          TOT_RETRY_HI       = 5;
  localparam int          TOT_RETRY_LO       = 3;
  localparam int          TOT_TIME_HI        = 2;
  localparam int          TOT_TIME_LO        = 0;
  // Reaction codes
  localparam logic [1:0]  TOT_RESP_IGNORE    = 2'h0;
  localparam logic [1:0]  TOT_RESP_RUN_THEN  = 2'h1;
  localparam logic [1:0]  TOT_RESP_RETRY     = 2'h2;
  localparam logic [1:0]  TOT_RESP_LATCH     = 2'h3;
  localparam logic [2:0]  TOT_RETRY_NONE     = 3'h0;
  localparam logic [2:0]  TOT_RETRY_FOREVER  = 3'h7;
  // Millisecond tick: 1 ms at 200 MHz
  localparam int          TOT_CLK_MHZ        = 200;
  localparam int          TOT_MS_US          = 1000;
  localparam int          TOT_MS_CYCLES      = TOT_CLK_MHZ * TOT_MS_US;
  // Sequencer states, one-hot
  typedef enum logic [5:0] {
    TOT_ST_OFF   = 6'h01,
    TOT_ST_WAIT  = 6'h02,
    TOT_ST_RISE  = 6'h04,
    TOT_ST_ON    = 6'h08,
    TOT_ST_GRACE = 6'h10,
    TOT_ST_HOLD  = 6'h20
  } tot_state_t;
endpackage : tot_pkg

/* rtl/tot_tick.sv */
`timescale 1ns/1ps
// Divider producing one-cycle enable pulses every PERIOD cycles
module tot_tick #(
  parameter int PERIOD = 200000
) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic clr,
  output logic      tick
);
  logic [31:0] cnt_q;
  logic        wrap;

  // Wrap decode
  assign wrap = (cnt_q == 32'(PERIOD - 1));
  assign tick = wrap;

  // Restartable count so each window starts aligned
  always_ff @(posedge clock) begin
    if (rst || clr || wrap) begin
      cnt_q <= 32'h0;
    end else begin
      cnt_q <= cnt_q + 32'h1;
    end
  end
endmodule : tot_tick

/* rtl/tot_seq.sv */
`timescale 1ns/1ps
//Contract
// - Fault when output misses threshold in time
// - Zero limit disables the timeout
// - Code 00 ignores fault, keeps running
// - Code 01 runs for delay, then retries
// - Code 10 disables output, then retries
// - Code 11 latches output off
// - Clear by bit, command, reset, bias
// - Clear by off-then-on enable command
// - Retry 000 means no restart
// - Retry 001 gives one restart
// - Retry 010 gives two restarts
// - Restart spacing from time field
// - Time code selects power-of-two units
// - Time unit follows output-voltage fault unit
// - Retry 011..110 give three to six
// - Retry 111 retries without limit
module tot_seq
  import tot_pkg::*;
#(
  parameter int MS_CYCLES = TOT_MS_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  input  wire logic [7:0]  cmd_code,
  input  wire logic [15:0] wr_data,
  output logic      [15:0] rd_data,
  input  wire logic        clear_faults,
  input  wire logic        clear_status_bit,
  input  wire logic        bias_lost,
  input  wire logic        enable_cmd,
  input  wire logic        turn_on_wait_done,
  input  wire logic        uv_reached_pin,
  input  wire logic        unit_tick,
  output logic             output_enable,
  output logic             fault_status,
  output logic             latched_off
);
  logic [15:0] limit_q;
  logic [7:0]  action_q;
  tot_state_t  state_q;
  tot_state_t  state_d;
  logic [15:0] ms_cnt_q;
  logic [7:0]  unit_cnt_q;
  logic [2:0]  tries_q;
  logic        fault_q;
  logic        latched_q;
  logic        en_prev_q;
  logic        uv_s1_q;
  logic        uv_s2_q;
  logic        ms_tick;
  logic        timing;

  wire  [1:0]  resp     = action_q[TOT_RESP_HI:TOT_RESP_LO];
  wire  [2:0]  retries  = action_q[TOT_RETRY_HI:TOT_RETRY_LO];
  wire  [2:0]  time_cd  = action_q[TOT_TIME_HI:TOT_TIME_LO];
  // Power-of-two units from the time code
  wire  [7:0]  delay_units = 8'h01 << time_cd;
  // Unit tick comes from the shared output-voltage fault unit
  wire         delay_done  = unit_tick && (unit_cnt_q + 8'h01 >= delay_units);
  wire         uv_ok       = uv_s2_q;
  // Zero limit never expires
  wire         limit_hit   = (limit_q != 16'h0000) && ms_tick && (ms_cnt_q + 16'h0001 >= limit_q);
  wire         timeout_ev  = (state_q == TOT_ST_RISE) && !uv_ok && limit_hit;
  wire         more_tries  = (retries == TOT_RETRY_FOREVER) || (tries_q < retries);
  // Off-then-on edge of the enable command clears a latch
  wire         reenable    = enable_cmd && !en_prev_q;
  wire         clear_ev    = clear_faults || clear_status_bit || bias_lost || reenable;
  wire         wr_limit    = wr_en && (cmd_code == TOT_CMD_LIMIT);
  wire         wr_action   = wr_en && (cmd_code == TOT_CMD_ACTION);
  // Sequencer events shared by the short register processes below
  wire         state_change = (state_d != state_q);
  wire         retry_start  = (state_q == TOT_ST_HOLD) && (state_d == TOT_ST_RISE);
  wire         seq_settled  = (state_d == TOT_ST_OFF) || (state_d == TOT_ST_ON);
  // Dropping to off while still commanded on means a fault shutdown
  wire         shut_latch   = (state_q != TOT_ST_OFF) && (state_d == TOT_ST_OFF) && enable_cmd;

  assign timing = (state_q == TOT_ST_RISE);

  tot_tick #(
    .PERIOD (MS_CYCLES)
  ) u_ms (
    .clock (clock),
    .rst   (rst),
    .clr   (!timing),
    .tick  (ms_tick)
  );

  // Level from the output comparator is asynchronous
  always_ff @(posedge clock) begin
    if (rst) begin
      uv_s1_q <= 1'b0;
      uv_s2_q <= 1'b0;
    end else begin
      uv_s1_q <= uv_reached_pin;
      uv_s2_q <= uv_s1_q;
    end
  end

  // Register writes
  always_ff @(posedge clock) begin
    if (rst) begin
      limit_q  <= TOT_LIMIT_RST;
      action_q <= TOT_ACTION_RST;
    end else begin
      if (wr_limit) limit_q <= wr_data;
      if (wr_action) action_q <= wr_data[7:0];
    end
  end

  // Read mux, registered
  always_ff @(posedge clock) begin
    if (rst) begin
      rd_data <= 16'h0000;
    end else if (rd_en) begin
      rd_data <= (cmd_code == TOT_CMD_LIMIT)  ? limit_q :
                 (cmd_code == TOT_CMD_ACTION) ? {8'h00, action_q} : 16'h0000;
    end
  end

  // Next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      TOT_ST_OFF: begin
        if (enable_cmd && !latched_q) state_d = TOT_ST_WAIT;
      end
      TOT_ST_WAIT: begin
        if (!enable_cmd) state_d = TOT_ST_OFF;
        else if (turn_on_wait_done) state_d = TOT_ST_RISE;
      end
      TOT_ST_RISE: begin
        if (!enable_cmd) state_d = TOT_ST_OFF;
        else if (uv_ok) state_d = TOT_ST_ON;
        else if (timeout_ev) begin
          case (resp)
            TOT_RESP_IGNORE:   state_d = TOT_ST_ON;
            TOT_RESP_RUN_THEN: state_d = TOT_ST_GRACE;
            TOT_RESP_RETRY:    state_d = more_tries ? TOT_ST_HOLD : TOT_ST_OFF;
            default:           state_d = TOT_ST_OFF;
          endcase
        end
      end
      TOT_ST_GRACE: begin
        if (!enable_cmd) state_d = TOT_ST_OFF;
        else if (uv_ok) state_d = TOT_ST_ON;
        else if (delay_done) state_d = more_tries ? TOT_ST_HOLD : TOT_ST_OFF;
      end
      TOT_ST_HOLD: begin
        if (!enable_cmd) state_d = TOT_ST_OFF;
        else if (delay_done) state_d = TOT_ST_RISE;
      end
      TOT_ST_ON: begin
        if (!enable_cmd) state_d = TOT_ST_OFF;
      end
      default: state_d = TOT_ST_OFF;
    endcase
  end

  // State register and enable history for the re-enable edge
  always_ff @(posedge clock) begin
    if (rst) begin
      state_q   <= TOT_ST_OFF;
      en_prev_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      en_prev_q <= enable_cmd;
    end
  end

  // Whole milliseconds spent rising, cleared outside the rise
  always_ff @(posedge clock) begin
    if (rst || !timing) begin
      ms_cnt_q <= 16'h0000;
    end else if (ms_tick) begin
      ms_cnt_q <= ms_cnt_q + 16'h0001;
    end
  end

  // Delay units since the state was entered; a tick on the entry edge is lost
  always_ff @(posedge clock) begin
    if (rst || state_change) begin
      unit_cnt_q <= 8'h00;
    end else if (unit_tick) begin
      unit_cnt_q <= unit_cnt_q + 8'h01;
    end
  end

  // Restarts used so far; wraps harmlessly only in the unlimited mode
  always_ff @(posedge clock) begin
    if (rst || seq_settled) begin
      tries_q <= 3'h0;
    end else if (retry_start) begin
      tries_q <= tries_q + 3'h1;
    end
  end

  // Sticky status; a new fault wins over a clear in the same cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      fault_q <= 1'b0;
    end else if (timeout_ev) begin
      fault_q <= 1'b1;
    end else if (clear_ev) begin
      fault_q <= 1'b0;
    end
  end

  // Shutdown latch; only a clearing event lets the output start again
  always_ff @(posedge clock) begin
    if (rst) begin
      latched_q <= 1'b0;
    end else if (shut_latch) begin
      latched_q <= 1'b1;
    end else if (clear_ev) begin
      latched_q <= 1'b0;
    end
  end

  // Output is driven while rising, on, or running through grace
  assign output_enable = (state_q == TOT_ST_RISE) || (state_q == TOT_ST_ON) || (state_q == TOT_ST_GRACE);
  assign fault_status  = fault_q;
  assign latched_off   = latched_q;
endmodule : tot_seq

/* sim/tot_seq_properties.sv */
`timescale 1ns/1ps
// Latch and status watcher on the sequencer's pins
module tot_chk (
  input wire logic clock,
  input wire logic rst,
  input wire logic clear_faults,
  input wire logic clear_status_bit,
  input wire logic bias_lost,
  input wire logic enable_cmd,
  input wire logic output_enable,
  input wire logic fault_status,
  input wire logic latched_off
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);
  // No clear command, status-bit clear or bias loss this cycle
  wire quiet = !clear_faults && !clear_status_bit && !bias_lost;
  // Latched state: output dark and sticky until a clearing event
  a_latch_no_out: assert property (latched_off |-> !output_enable)
    else $error("output on while latched");
  a_latch_holds: assert property (latched_off && quiet && $stable(enable_cmd) |=> latched_off)
    else $error("latch dropped without cause");
  a_cmd_clears: assert property (latched_off && clear_faults |=> !latched_off)
    else $error("clear command left latch set");
  a_bit_clears: assert property (latched_off && clear_status_bit |=> !latched_off && !fault_status)
    else $error("status clear left latch set");
  a_bias_clears: assert property (latched_off && bias_lost |=> !latched_off)
    else $error("bias loss left latch set");
  a_cycle_clears: assert property (latched_off && $rose(enable_cmd) |=> !latched_off)
    else $error("off then on left latch set");
  // Status must not vanish on its own, and no latch without it
  a_status_sticky: assert property (fault_status && quiet && $stable(enable_cmd) |=> fault_status)
    else $error("fault status dropped");
  a_latch_flags: assert property ($rose(latched_off) |-> fault_status)
    else $error("latched without fault status");
endmodule : tot_chk

bind tot_seq tot_chk u_chk (
  .clock(clock), .rst(rst), .clear_faults(clear_faults), .clear_status_bit(clear_status_bit),
  .bias_lost(bias_lost), .enable_cmd(enable_cmd), .output_enable(output_enable),
  .fault_status(fault_status), .latched_off(latched_off)
);

/* sim/tot_host.sv */
`timescale 1ns/1ps
// Power manager: register bus master and enable control
module tot_host (
  input  wire logic        clock,
  input  wire logic [15:0] rd_data,
  output logic             wr_en,
  output logic             rd_en,
  output logic      [7:0]  cmd_code,
  output logic      [15:0] wr_data,
  output logic             clear_faults,
  output logic             clear_status_bit,
  output logic             enable_cmd
);
  // Bus and strobes idle from time zero
  initial begin
    {wr_en, rd_en, cmd_code, wr_data} = 26'h0;
    {clear_faults, clear_status_bit, enable_cmd} = 3'h0;
  end
  // Data inverted on release so stale values never look valid
  task automatic wr(input logic [7:0] c, input logic [15:0] v);
    @(posedge clock) #1 {wr_en, cmd_code, wr_data} = {1'b1, c, v};
    @(posedge clock) #1 {wr_en, wr_data} = {1'b0, ~v};
  endtask : wr
  // Read data is taken once the strobe edge has updated it
  task automatic rd(input logic [7:0] c, output logic [15:0] v);
    @(posedge clock) #1 {rd_en, cmd_code} = {1'b1, c};
    @(posedge clock) #1 rd_en = 1'b0;
    v = rd_data;
  endtask : rd
  task automatic en(input logic v);
    @(posedge clock) #1 enable_cmd = v;
  endtask : en
  // One-cycle pulse of either clearing strobe
  task automatic clr(input logic cmd);
    @(posedge clock) #1 {clear_faults, clear_status_bit} = {cmd, !cmd};
    @(posedge clock) #1 {clear_faults, clear_status_bit} = 2'b00;
  endtask : clr
endmodule : tot_host

/* sim/tot_seq_bench.sv */
`timescale 1ns/1ps
module tot_seq_bench;
  import tot_pkg::*;
  typedef struct packed {
    logic [15:0] lim;
    logic [7:0]  act;
    logic        uv;
    logic [2:0]  exp;
    logic [2:0]  msk;
  } tot_row_t;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        bias_lost = 1'b0;
  logic        turn_on_wait_done = 1'b0;
  logic        uv_reached_pin = 1'b0;
  logic        unit_tick = 1'b0;
  logic        wr_en, rd_en, clear_faults, clear_status_bit, enable_cmd, output_enable, fault_status, latched_off;
  logic [7:0]  cmd_code;
  logic [15:0] wr_data, rd_data, d;
  int          fails = 0;
  int          checks = 0;
  int          cyc = 0;
  int          n;
  // Limit, action, early threshold, expected {on, fault, latched}, mask
  tot_row_t rows [10] = '{
    '{16'h0000, 8'hc0, 1'b0, 3'b100, 3'b111},
    '{16'h0002, 8'h00, 1'b0, 3'b110, 3'b111},
    '{16'h0002, 8'hc0, 1'b0, 3'b011, 3'b111},
    '{16'h0002, 8'h80, 1'b0, 3'b011, 3'b111},
    '{16'h0002, 8'h88, 1'b0, 3'b011, 3'b111},
    '{16'h0002, 8'h90, 1'b0, 3'b011, 3'b111},
    '{16'h0002, 8'hb0, 1'b0, 3'b011, 3'b111},
    '{16'h0002, 8'h40, 1'b0, 3'b011, 3'b111},
    '{16'h0002, 8'hb8, 1'b0, 3'b010, 3'b011},
    '{16'h0002, 8'hc0, 1'b1, 3'b100, 3'b111}
  };
  always #2.5 clock = ~clock;
  // Cycle count, hang guard and an eight-clock delay unit
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      print_verdict();
    end
  end
  always @(posedge clock) #1 unit_tick = (cyc % 8 == 0);
  // Short millisecond keeps each attempt near twenty clocks
  tot_seq #(.MS_CYCLES(10)) dut (
    .clock(clock), .rst(rst), .wr_en(wr_en), .rd_en(rd_en), .cmd_code(cmd_code), .wr_data(wr_data),
    .rd_data(rd_data), .clear_faults(clear_faults), .clear_status_bit(clear_status_bit), .bias_lost(bias_lost),
    .enable_cmd(enable_cmd), .turn_on_wait_done(turn_on_wait_done), .uv_reached_pin(uv_reached_pin),
    .unit_tick(unit_tick), .output_enable(output_enable), .fault_status(fault_status), .latched_off(latched_off)
  );
  tot_host host (
    .clock(clock), .rd_data(rd_data), .wr_en(wr_en), .rd_en(rd_en), .cmd_code(cmd_code), .wr_data(wr_data),
    .clear_faults(clear_faults), .clear_status_bit(clear_status_bit), .enable_cmd(enable_cmd)
  );
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic print_verdict;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict
  // Fresh reset, program both registers, then start one rise
  task automatic start(input logic [15:0] lim, input logic [7:0] act, input logic u);
    host.en(1'b0);
    @(posedge clock) #1 rst = 1'b1;
    uv_reached_pin = u;
    @(posedge clock) #1 rst = 1'b0;
    host.wr(TOT_CMD_LIMIT, lim);
    host.wr(TOT_CMD_ACTION, {8'h00, act});
    host.en(1'b1);
    @(posedge clock) #1 turn_on_wait_done = 1'b1;
    @(posedge clock) #1 turn_on_wait_done = 1'b0;
  endtask : start
  initial begin
    repeat (3) @(posedge clock);
    #1 rst = 1'b0;
    // Reset values, read-back, and an undecoded code
    host.rd(TOT_CMD_LIMIT, d);
    check(d, TOT_LIMIT_RST);
    host.rd(TOT_CMD_ACTION, d);
    check(d, {8'h00, TOT_ACTION_RST});
    host.wr(TOT_CMD_LIMIT, 16'ha5c3);
    host.wr(8'h64, 16'hffff);
    host.rd(TOT_CMD_LIMIT, d);
    check(d, 16'ha5c3);
    host.rd(8'h64, d);
    check(d, 16'h0000);
    foreach (rows[i]) begin
      start(rows[i].lim, rows[i].act, rows[i].uv);
      repeat (400) @(posedge clock);
      #1;
      check(16'({output_enable, fault_status, latched_off} & rows[i].msk), 16'(rows[i].exp));
    end
    // Every way out of a latched shutdown other than reset
    for (int k = 0; k < 4; k++) begin
      start(16'h0002, 8'hc0, 1'b0);
      repeat (60) @(posedge clock);
      case (k)
        0: host.clr(1'b1);
        1: host.clr(1'b0);
        2: begin
          host.en(1'b0);
          host.en(1'b1);
        end
        default: begin
          @(posedge clock) #1 bias_lost = 1'b1;
          @(posedge clock) #1 bias_lost = 1'b0;
        end
      endcase
      @(posedge clock) #1;
      check(16'(latched_off), 16'h0000);
      check(16'(fault_status), 16'h0000);
    end
    // Off time between attempts: eight units of eight clocks
    start(16'h0002, 8'h8b, 1'b0);
    n = 0;
    repeat (200) begin
      @(posedge clock) #1;
      if (fault_status === 1'b1 && output_enable === 1'b0 && latched_off === 1'b0) n++;
    end
    check(16'(n >= 56 && n <= 67), 16'h0001);
    print_verdict();
  end
endmodule : tot_seq_bench
